// ### rtl/alert_compare.sv
// Limit comparator: selects the highest enabled alert function and tests it
`timescale 1ns/1ns
module alert_compare
  import monitor_regs_pkg::*;
(
  // Selection and data
  input wire logic [15:0] select_in,
  input wire logic [15:0] threshold_in,
  input wire measure_t meas_in,
  input wire logic conv_done_in,
  // Result
  output logic hit_out
);

  logic [5:0] en;

  // Highest enable bit takes priority so at most one function is active
  always_comb begin
    en = select_in[EN_SHUNT_OVER:EN_CONV_READY];
    hit_out = 1'b0;
    if (en[5]) begin
      hit_out = $signed(meas_in.shunt) > $signed(threshold_in);
    end else if (en[4]) begin
      hit_out = $signed(meas_in.shunt) < $signed(threshold_in);
    end else if (en[3]) begin
      hit_out = meas_in.bus > threshold_in;
    end else if (en[2]) begin
      hit_out = meas_in.bus < threshold_in;
    end else if (en[1]) begin
      hit_out = meas_in.power > threshold_in;
    end else if (en[0]) begin
      hit_out = conv_done_in;
    end
  end

endmodule

// ### rtl/monitor_regs.sv
// Register bank of the monitor: configuration, alert select/flags, threshold, die identity
`timescale 1ns/1ns
module monitor_regs
  import monitor_regs_pkg::*;
#(
  parameter logic [11:0] DIE_CODE = 12'h123, // Arbitrary value
  parameter logic [3:0] DIE_REV = 4'h1 // Arbitrary value
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register access from the serial interface
  input wire reg_req_t req_in,
  output logic [15:0] rdata_out,
  // Measurement front end
  input wire logic conv_done_in,
  input wire measure_t meas_in,
  input wire logic cal_valid_in,
  // Configuration towards the front end
  output logic [15:0] config_out,
  output logic power_valid_out,
  output logic config_write_out,
  // Alert pin, open collector
  output logic alert_o_out,
  output logic alert_oe_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] config_reg;
    logic [15:0] alert_sel;
    logic [15:0] threshold;
    logic [15:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic hit;
  logic alert_active;

  alert_compare u_cmp (
    .select_in(s_q.alert_sel),
    .threshold_in(s_q.threshold),
    .meas_in(meas_in),
    .conv_done_in(conv_done_in),
    .hit_out(hit)
  );

  function automatic logic [15:0] read_mux(input logic [7:0] ptr, input state_t s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (ptr)
      PTR_CONFIG: v = s.config_reg;
      PTR_ALERT_SEL: v = s.alert_sel;
      PTR_THRESHOLD: v = s.threshold;
      PTR_DIE_ID: v = {DIE_CODE, DIE_REV};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (req_in.rd) begin
      s_d.rdata = read_mux(req_in.ptr, s_q);
    end
    // Clears from a select read come first so same-cycle events win
    if (req_in.rd && req_in.ptr == PTR_ALERT_SEL) begin
      if (s_q.alert_sel[BIT_LATCH]) begin
        s_d.alert_sel[FLAG_ALERT] = 1'b0;
      end
      s_d.alert_sel[FLAG_CONV_READY] = 1'b0;
      s_d.alert_sel[FLAG_OVERFLOW] = 1'b0;
    end
    if (req_in.wr) begin
      unique case (req_in.ptr)
        PTR_CONFIG: begin
          if (req_in.wdata[CFG_RESET_BIT]) begin
            s_d.config_reg = CONFIG_RESET;
            s_d.alert_sel = ALERT_SEL_RESET;
            s_d.threshold = THRESHOLD_RESET;
          end else begin
            s_d.config_reg = req_in.wdata;
          end
          // Power-down modes leave the ready flag alone
          if (req_in.wdata[2:0] != 3'b000 && req_in.wdata[2:0] != 3'b100) begin
            s_d.alert_sel[FLAG_CONV_READY] = 1'b0;
          end
        end
        PTR_ALERT_SEL: begin
          s_d.alert_sel[15:10] = req_in.wdata[15:10];
          s_d.alert_sel[1:0] = req_in.wdata[1:0];
        end
        PTR_THRESHOLD: s_d.threshold = req_in.wdata;
        default: s_d = s_d;
      endcase
    end
    if (conv_done_in) begin
      s_d.alert_sel[FLAG_CONV_READY] = 1'b1;
      if (meas_in.overflow) begin
        s_d.alert_sel[FLAG_OVERFLOW] = 1'b1;
      end
      if (hit) begin
        s_d.alert_sel[FLAG_ALERT] = 1'b1;
      end else if (!s_q.alert_sel[BIT_LATCH]) begin
        s_d.alert_sel[FLAG_ALERT] = 1'b0;
      end
    end
    s_d.config_reg[CFG_RESET_BIT] = 1'b0;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q <= '{config_reg: CONFIG_RESET, alert_sel: ALERT_SEL_RESET,
               threshold: THRESHOLD_RESET, rdata: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign alert_active = s_q.alert_sel[FLAG_ALERT];
  // Open collector: only the low level is driven; high comes from the pull-up
  always_comb begin
    alert_o_out = 1'b0;
    alert_oe_out = ~(alert_active ^ s_q.alert_sel[BIT_POLARITY]);
  end

  assign rdata_out = s_q.rdata;
  assign config_out = s_q.config_reg;
  assign power_valid_out = cal_valid_in;
  assign config_write_out = req_in.wr && req_in.ptr == PTR_CONFIG;

endmodule

// ### rtl/monitor_regs_pkg.sv
// Package: register map, field layout, reset values and carriers for the monitor register bank
package monitor_regs_pkg;

  // ------------------------------------------------------------
  // Register pointers
  // ------------------------------------------------------------
  localparam logic [7:0] PTR_CONFIG = 8'h00;
  localparam logic [7:0] PTR_ALERT_SEL = 8'h06;
  localparam logic [7:0] PTR_THRESHOLD = 8'h07;
  localparam logic [7:0] PTR_DIE_ID = 8'hff;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_RESET_BIT = 15;
  localparam int EN_SHUNT_OVER = 15;
  localparam int EN_SHUNT_UNDER = 14;
  localparam int EN_BUS_OVER = 13;
  localparam int EN_BUS_UNDER = 12;
  localparam int EN_POWER_OVER = 11;
  localparam int EN_CONV_READY = 10;
  localparam int FLAG_ALERT = 4;
  localparam int FLAG_CONV_READY = 3;
  localparam int FLAG_OVERFLOW = 2;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_LATCH = 0;
  localparam int NUM_ALERT_FUNCS = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CONFIG_RESET = 16'h4127;
  localparam logic [15:0] ALERT_SEL_RESET = 16'h0000;
  localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [15:0] CAL_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
    logic overflow;
  } measure_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// ### verification/host_model.sv
// Host model: one register word per transfer
`timescale 1ns/1ns
module host_model
  import monitor_regs_pkg::*;
(
  input wire logic clk_in,
  output reg_req_t req_out
);
  initial req_out = '0;
  task automatic xfer(input logic w, input logic [7:0] p, input logic [15:0] d);
    @(negedge clk_in);
    req_out = '{w, !w, p, d};
    @(negedge clk_in);
    req_out = '{1'b0, 1'b0, ~p, ~d}; // Idle lines show no stale value
  endtask
endmodule

// ### verification/monitor_regs_sva.sv
// Checker: port assertions for the monitor register bank
`timescale 1ns/1ns
module monitor_regs_sva
  import monitor_regs_pkg::*;
#(parameter logic [11:0] DIE_CODE = 12'h123, parameter logic [3:0] DIE_REV = 4'h1)(
  input wire logic clk_in, reset_in, conv_done_in, cal_valid_in,
  input wire reg_req_t req_in,
  input wire logic [15:0] rdata_out, config_out,
  input wire logic power_valid_out, config_write_out, alert_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic [7:0] p = req_in.ptr;
  AST_ID: assert property (req_in.rd && p == PTR_DIE_ID
    |=> rdata_out == {DIE_CODE, DIE_REV}) else $error("id read");
  AST_ID_WR: assert property (req_in.wr && p == PTR_DIE_ID
    |=> $stable(config_out)) else $error("id write");
  AST_LIMIT: assert property (req_in.wr && p == PTR_THRESHOLD
    ##2 req_in.rd && p == PTR_THRESHOLD |=> rdata_out == $past(req_in.wdata, 3))
    else $error("limit");
  AST_CFG: assert property (req_in.wr && p == PTR_CONFIG && !req_in.wdata[15]
    |=> config_out == $past(req_in.wdata)) else $error("config");
  AST_CFG_PULSE: assert property (req_in.wr && p == PTR_CONFIG
    |-> config_write_out) else $error("config pulse");
  AST_SELF_CLR: assert property (!config_out[CFG_RESET_BIT]) else $error("d15");
  AST_POWER: assert property (power_valid_out == cal_valid_in) else $error("power");
  // Only a select read or a config write may drop a flag without a conversion
  AST_ID_KEEPS_ALERT: assert property (req_in.rd && p == PTR_DIE_ID && !conv_done_in
    |=> $stable(alert_oe_out)) else $error("alert moved");
endmodule
bind monitor_regs monitor_regs_sva #(.DIE_CODE(DIE_CODE), .DIE_REV(DIE_REV)) i_monitor_regs_sva (
  .clk_in, .reset_in, .conv_done_in, .cal_valid_in, .req_in, .rdata_out, .config_out,
  .power_valid_out, .config_write_out, .alert_oe_out);

// ### verification/monitor_regs_tb.sv
// Testbench: register map, identity and alert behaviour of the monitor bank
`timescale 1ns/1ns
module monitor_regs_tb;
  import monitor_regs_pkg::*;
  localparam logic [15:0] ID = 16'h5a37; // Arbitrary identity value
  logic clk_in = 1'b0, reset_in = 1'b1, conv_done_in = 1'b0, cal_valid_in = 1'b0;
  logic power_valid_out, alert_oe_out;
  logic [15:0] rdata_out, config_out, v;
  measure_t meas_in = '0;
  reg_req_t req;
  int fail_count = 0, compares = 0, cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  host_model i_host_model (.clk_in, .req_out(req));
  monitor_regs #(.DIE_CODE(ID[15:4]), .DIE_REV(ID[3:0])) i_monitor_regs (.clk_in, .reset_in,
    .req_in(req), .rdata_out, .conv_done_in, .meas_in, .cal_valid_in, .config_out,
    .power_valid_out, .config_write_out(), .alert_o_out(), .alert_oe_out);
  function automatic logic [15:0] sel_back(input logic [15:0] d);
    return d & 16'hfc03; // Flags and reserved bits are not writable
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    i_host_model.xfer(1'b1, p, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] p, input logic [15:0] e);
    i_host_model.xfer(1'b0, p, 16'h0000);
    chk(n, e, rdata_out);
  endtask
  task automatic conv(input logic [15:0] s, input logic o);
    @(negedge clk_in);
    conv_done_in = 1'b1;
    meas_in = '{s, 16'h0000, 16'h0000, o};
    @(negedge clk_in);
    conv_done_in = 1'b0;
    meas_in = ~meas_in;
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    void'($urandom(32'h1c3a));
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    chk("cfg rst", CONFIG_RESET, config_out);
    chk("pin idle", 16'h0001, alert_oe_out);
    rchk("sel rst", PTR_ALERT_SEL, ALERT_SEL_RESET);
    rchk("lim rst", PTR_THRESHOLD, THRESHOLD_RESET);
    wr(PTR_DIE_ID, 16'($urandom));
    rchk("id", PTR_DIE_ID, ID);
    rchk("unmapped", 8'h20, 16'h0000);
    repeat (8) begin
      v = 16'($urandom);
      cal_valid_in = v[3];
      wr(PTR_THRESHOLD, v);
      chk("power", 16'(v[3]), 16'(power_valid_out));
      rchk("lim", PTR_THRESHOLD, v);
      v[15] = 1'b0;
      wr(PTR_CONFIG, v);
      rchk("cfg", PTR_CONFIG, v);
      wr(PTR_ALERT_SEL, v);
      rchk("sel", PTR_ALERT_SEL, sel_back(v));
    end
    wr(PTR_CONFIG, CONFIG_RESET);
    wr(PTR_THRESHOLD, 16'h0100);
    wr(PTR_ALERT_SEL, 16'h8000);
    conv(16'h0200, 1'b0);
    chk("alert", 16'h0000, alert_oe_out);
    rchk("flags", PTR_ALERT_SEL, 16'h8018);
    conv(16'hff00, 1'b1);
    chk("clear", 16'h0001, alert_oe_out);
    rchk("ovf", PTR_ALERT_SEL, 16'h800c);
    wr(PTR_ALERT_SEL, 16'h8001);
    conv(16'h0200, 1'b0);
    conv(16'h0010, 1'b0);
    chk("latch", 16'h0000, alert_oe_out);
    rchk("lflags", PTR_ALERT_SEL, 16'h8019);
    chk("unlatch", 16'h0001, alert_oe_out);
    wr(PTR_ALERT_SEL, 16'h0402);
    chk("inv idle", 16'h0000, alert_oe_out);
    conv(16'h0000, 1'b0);
    chk("ready", 16'h0001, alert_oe_out);
    // Remaining limit functions: power over, bus under, shunt under, bus over
    wr(PTR_ALERT_SEL, 16'h0800);
    conv(16'h0200, 1'b0);
    chk("pwr over", 16'h0001, alert_oe_out);
    wr(PTR_ALERT_SEL, 16'h1000);
    conv(16'h0200, 1'b0);
    chk("bus under", 16'h0000, alert_oe_out);
    wr(PTR_ALERT_SEL, 16'h4000);
    conv(16'h0200, 1'b0);
    chk("sh under no", 16'h0001, alert_oe_out);
    conv(16'hff00, 1'b0);
    chk("sh under", 16'h0000, alert_oe_out);
    wr(PTR_ALERT_SEL, 16'h2000);
    conv(16'h0200, 1'b0);
    chk("bus over", 16'h0001, alert_oe_out);
    stop_test;
  end
endmodule
